// ### verilog/tmr_timer16.sv
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// [R1] Action 0 counts rising event edges; action 1 counts both edges.
// [R2] Action 2 counts prescaled ticks only while the event is high.
// [R3] Action 3 counts every tick, up when event low, down when high.
// [R4] Action 3 latches the direction from the event on each step.
// [R5] Enable bit 0 gates event actions; action field sits in bits 3:1.
// [R6] Bits 4, 5, 6 enable compare channel 0, 1, 2 interrupts.
// [R7] Bit 0 enables the wrap interrupt while its flag is set.
// [R8] A channel flag sets when the count equals its compare value.
// [R9] Compare flags clear only by writing one; hardware never clears.
// [R10] Wrap flag sets at TOP counting up or BOTTOM counting down.
// [R11] Wrap flag clears only by writing one to its bit.
// [R12] Halted with run bit 0, counting stops and events are ignored.
// [R13] With run bit 1 the timer runs on while halted.
// [R14] One shared byte latch at 0x0f serves all 16-bit registers.
// [R15] Count value: low byte at 0x20, high byte at 0x21.
// [R16] Period gives TOP, sits at 0x26, resets to 0xffff.
// [R17] Compare values are compared continuously with the count.
// [R18] On update each compare value loads from its buffer if that buffer is valid.
// [R19] Compare n sits at 0x28 plus 2n, low then high, reset zero.
// [R20] Buffer write sets its valid bit; update clears all valid bits.
// [R21] Lock bit blocks wrap updates; a commanded update still loads.
// [R22] Period buffer write sets the period buffer valid bit.
// [R23] Action codes 4 to 7 give no counting at all.
// [R24] Low write parks in latch, high write commits; low read latches high.
module tmr_timer16 #(
  parameter int NCH = 3
) (
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       event_i,
  input  wire logic       count_tick_i,
  input  wire logic       debug_halt_i,
  output logic [7:0]      rdata_o,
  output logic            irq_o,
  output logic [NCH-1:0]  cmp_match_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]     event_action_control_reg;
  logic [7:0]     inten_reg;
  logic [7:0]     flags_reg;
  logic [7:0]     temp_reg;
  logic           run_reg;
  logic           dir_reg;
  logic           lock_reg;
  logic [15:0]    cnt_reg;
  logic [15:0]    cnt_next;
  logic [15:0]    per_reg;
  logic [15:0]    period_buffer_reg;
  logic           period_buffer_valid_reg;
  logic [7:0]     rdata_reg;
  logic           irq_reg;
  logic           ev_s1_reg;
  logic           ev_s2_reg;
  logic           ev_prev_reg;
  logic           active;
  logic           step;
  logic           down;
  logic           wrap;
  logic           force_upd;
  logic           upd;
  logic [6:0]     wa;
  logic           wr_lo;
  logic           wr_hi;
  logic           rd_lo;
  logic [15:0]    wword;
  logic           cnt_wr;
  logic           per_wr;
  logic           period_buffer_wr;
  logic           hit16;
  logic [15:0]    rword;
  logic [7:0]     rbyte;
  logic [15:0]    cmp_val  [NCH];
  logic [15:0]    cmp_bufv [NCH];
  logic [NCH-1:0] cmp_bv;
  logic [NCH-1:0] cmp_hit;
  tmr_pkg::tmr_act_t act;

  // Channel count must fit the three enable and flag positions.
  if (NCH < 1 || NCH > 3) begin : g_bad_nch
    $error("NCH must be 1 to 3");
  end

  // ****************************************************************
  // Event input and count step selection
  // ****************************************************************

  // The event input is resynchronised before any logic looks at it.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_s1_reg   <= 1'b0;
      ev_s2_reg   <= 1'b0;
      ev_prev_reg <= 1'b0;
    end else begin
      ev_s1_reg   <= event_i;
      ev_s2_reg   <= ev_s1_reg;
      ev_prev_reg <= ev_s2_reg;
    end
  end

  assign act    = tmr_pkg::tmr_act_t'(event_action_control_reg[tmr_pkg::EV_ACT_LSB +: 3]);
  assign active = run_reg || !debug_halt_i; // [R12] [R13]

  // Picks whether the counter steps this cycle and in which direction.
  always_comb begin
    step = count_tick_i;
    down = dir_reg;
    if (event_action_control_reg[tmr_pkg::EV_EN_BIT]) begin // [R5]
      case (act)
        tmr_pkg::ACTION_RISING_EDGE: begin
          step = ev_s2_reg && !ev_prev_reg; // [R1]
        end
        tmr_pkg::ACTION_BOTH_EDGES: begin
          step = ev_s2_reg ^ ev_prev_reg; // [R1]
        end
        tmr_pkg::ACTION_HIGH_LEVEL: begin
          step = count_tick_i && ev_s2_reg; // [R2]
        end
        tmr_pkg::ACTION_DIRECTION_CONTROL: begin
          step = count_tick_i; // [R3]
          down = ev_s2_reg; // [R3]
        end
        default: begin
          step = 1'b0; // [R23]
        end
      endcase
    end
    if (!active) begin
      step = 1'b0; // [R12]
    end
  end

  // Next count with wrap at TOP upward and at BOTTOM downward.
  always_comb begin
    wrap     = 1'b0;
    cnt_next = cnt_reg;
    if (step) begin
      if (!down && cnt_reg == per_reg) begin
        cnt_next = tmr_pkg::CNT_RST;
        wrap     = 1'b1; // [R10]
      end else if (down && cnt_reg == tmr_pkg::CNT_RST) begin
        cnt_next = per_reg;
        wrap     = 1'b1; // [R10]
      end else if (down) begin
        cnt_next = cnt_reg - 16'h0001;
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  assign force_upd = wr_i && addr_i == tmr_pkg::A_CTRL && wdata_i[tmr_pkg::CTRL_UPD];
  assign upd       = (wrap && !lock_reg) || force_upd; // [R21]

  // ****************************************************************
  // Register bus decode
  // ****************************************************************
  assign wa        = addr_i[7:1];
  assign wr_lo     = wr_i && hit16 && !addr_i[0];
  assign wr_hi     = wr_i && hit16 && addr_i[0];
  assign rd_lo     = rd_i && hit16 && !addr_i[0];
  assign wword     = {wdata_i, temp_reg}; // [R24]
  assign cnt_wr    = wr_hi && wa == tmr_pkg::A_CNT[7:1]; // [R15]
  assign per_wr    = wr_hi && wa == tmr_pkg::A_PER[7:1]; // [R16]
  assign period_buffer_wr = wr_hi && wa == tmr_pkg::A_PERIOD_BUFFER[7:1];

  // Selects the 16-bit register that a byte address falls in.
  always_comb begin
    hit16 = 1'b1;
    rword = 16'h0000;
    if (wa == tmr_pkg::A_CNT[7:1]) begin
      rword = cnt_reg;
    end else if (wa == tmr_pkg::A_PER[7:1]) begin
      rword = per_reg;
    end else if (wa == tmr_pkg::A_PERIOD_BUFFER[7:1]) begin
      rword = period_buffer_reg;
    end else begin
      hit16 = 1'b0;
    end
    for (int i = 0; i < NCH; i++) begin
      if (wa == 7'(tmr_pkg::A_CMP[7:1] + 7'(i))) begin // [R19]
        hit16 = 1'b1;
        rword = cmp_val[i];
      end
      if (wa == 7'(tmr_pkg::A_CMPBUF[7:1] + 7'(i))) begin
        hit16 = 1'b1;
        rword = cmp_bufv[i];
      end
    end
  end

  // Byte read mux; unmapped addresses read zero.
  always_comb begin
    rbyte = 8'h00;
    if (hit16) begin
      rbyte = addr_i[0] ? temp_reg : rword[7:0]; // [R24]
    end else begin
      case (addr_i)
        tmr_pkg::A_CTRL:   rbyte = {6'h00, lock_reg, dir_reg};
        tmr_pkg::A_BVALID: rbyte = {4'h0, 3'(cmp_bv), period_buffer_valid_reg};
        tmr_pkg::A_EVENT_ACTION_CONTROL: rbyte = event_action_control_reg;
        tmr_pkg::A_INTEN:  rbyte = inten_reg;
        tmr_pkg::A_FLAGS:  rbyte = flags_reg;
        tmr_pkg::A_DBG:    rbyte = {7'h00, run_reg};
        tmr_pkg::A_TEMP:   rbyte = temp_reg; // [R14]
        default:           rbyte = 8'h00;
      endcase
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= tmr_pkg::REG8_RST;
    end else begin
      rdata_reg <= rd_i ? rbyte : 8'h00;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************

  // Event control, interrupt enables and run-while-halted bit.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      event_action_control_reg <= tmr_pkg::REG8_RST;
      inten_reg  <= tmr_pkg::REG8_RST;
      run_reg    <= 1'b0;
    end else if (wr_i) begin
      if (addr_i == tmr_pkg::A_EVENT_ACTION_CONTROL) begin
        event_action_control_reg <= {4'h0, wdata_i[3:0]}; // [R5]
      end
      if (addr_i == tmr_pkg::A_INTEN) begin
        inten_reg <= wdata_i & 8'h71; // [R6] [R7]
      end
      if (addr_i == tmr_pkg::A_DBG) begin
        run_reg <= wdata_i[tmr_pkg::DBG_RUN]; // [R13]
      end
    end
  end

  // Lock bit and count direction; action 3 latches direction on a step.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lock_reg <= 1'b0;
      dir_reg  <= 1'b0;
    end else begin
      if (wr_i && addr_i == tmr_pkg::A_CTRL) begin
        lock_reg <= wdata_i[tmr_pkg::CTRL_LOCK];
      end
      if (step && event_action_control_reg[tmr_pkg::EV_EN_BIT]
          && act == tmr_pkg::ACTION_DIRECTION_CONTROL) begin
        dir_reg <= ev_s2_reg; // [R4]
      end else if (wr_i && addr_i == tmr_pkg::A_CTRL) begin
        dir_reg <= wdata_i[tmr_pkg::CTRL_DIR];
      end
    end
  end

  // Shared byte latch: direct access, low-byte writes, low-byte reads.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      temp_reg <= tmr_pkg::REG8_RST;
    end else if (wr_i && addr_i == tmr_pkg::A_TEMP) begin
      temp_reg <= wdata_i; // [R14]
    end else if (wr_lo) begin
      temp_reg <= wdata_i; // [R24]
    end else if (rd_lo) begin
      temp_reg <= rword[15:8]; // [R24]
    end
  end

  // ****************************************************************
  // Counter, period and period buffer
  // ****************************************************************

  // A software write of the count wins over a step in the same cycle.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= tmr_pkg::CNT_RST;
    end else if (cnt_wr) begin
      cnt_reg <= wword; // [R15]
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Period loads from a valid buffer on update.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      per_reg <= tmr_pkg::PER_RST; // [R16]
    end else if (per_wr) begin
      per_reg <= wword;
    end else if (upd && period_buffer_valid_reg) begin
      per_reg <= period_buffer_reg; // [R21]
    end
  end

  // Period buffer; a write marks it valid, an update clears the mark.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      period_buffer_reg <= tmr_pkg::PER_RST;
      period_buffer_valid_reg  <= 1'b0;
    end else if (period_buffer_wr) begin
      period_buffer_reg <= wword;
      period_buffer_valid_reg  <= 1'b1; // [R22]
    end else if (upd) begin
      period_buffer_valid_reg  <= 1'b0; // [R20]
    end
  end

  // ****************************************************************
  // Compare channels
  // ****************************************************************
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    tmr_cmp_if cif ();

    assign cif.cnt    = cnt_reg;
    assign cif.upd    = upd; // [R18]
    assign cif.wdata  = wword;
    assign cif.wr_val = wr_hi && wa == 7'(tmr_pkg::A_CMP[7:1] + 7'(g)); // [R19]
    assign cif.wr_buf = wr_hi && wa == 7'(tmr_pkg::A_CMPBUF[7:1] + 7'(g));
    assign cmp_val[g]  = cif.val;
    assign cmp_bufv[g] = cif.bufv;
    assign cmp_bv[g]   = cif.bv;
    assign cmp_hit[g]  = cif.hit;
    assign cmp_match_o[g] = cif.match; // [R17]

    tmr_cmp_chan u_chan (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .bus    (cif)
    );
  end

  // ****************************************************************
  // Flags and interrupt request
  // ****************************************************************

  // Hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_reg <= tmr_pkg::REG8_RST;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (cmp_hit[i]) begin
          flags_reg[tmr_pkg::IE_CMP_LSB + i] <= 1'b1; // [R8]
        end else if (wr_i && addr_i == tmr_pkg::A_FLAGS
                     && wdata_i[tmr_pkg::IE_CMP_LSB + i]) begin
          flags_reg[tmr_pkg::IE_CMP_LSB + i] <= 1'b0; // [R9]
        end
      end
      if (wrap) begin
        flags_reg[tmr_pkg::IE_WRAP_BIT] <= 1'b1; // [R10]
      end else if (wr_i && addr_i == tmr_pkg::A_FLAGS
                   && wdata_i[tmr_pkg::IE_WRAP_BIT]) begin
        flags_reg[tmr_pkg::IE_WRAP_BIT] <= 1'b0; // [R11]
      end
    end
  end

  // Request stands while any enabled flag is set.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags_reg & inten_reg); // [R6] [R7]
    end
  end

  assign rdata_o = rdata_reg;
  assign irq_o   = irq_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_OVF_STICKY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    flags_reg[0] && !(wr_i && addr_i == tmr_pkg::A_FLAGS) |=> flags_reg[0]) // [R11]
    else $error("wrap flag cleared without a write");

  AST_CMP_STICKY: assert property (@(posedge clk_i) disable iff (!nrst_i)
    flags_reg[4] && !(wr_i && addr_i == tmr_pkg::A_FLAGS) |=> flags_reg[4]) // [R9]
    else $error("compare flag cleared without a write");

  AST_WRAP_UP: assert property (@(posedge clk_i) disable iff (!nrst_i)
    step && !down && cnt_reg == per_reg && !cnt_wr |=> cnt_reg == 16'h0000 && flags_reg[0]) // [R10]
    else $error("no wrap to zero at TOP");

  AST_HALT: assert property (@(posedge clk_i) disable iff (!nrst_i)
    debug_halt_i && !run_reg && !cnt_wr |=> $stable(cnt_reg)) // [R12]
    else $error("count moved while halted");

  AST_HIGH_LVL: assert property (@(posedge clk_i) disable iff (!nrst_i)
    event_action_control_reg[0] && act == tmr_pkg::ACTION_HIGH_LEVEL && !ev_s2_reg && !cnt_wr
    |=> $stable(cnt_reg)) // [R2]
    else $error("count moved with event low");

  AST_RESERVED: assert property (@(posedge clk_i) disable iff (!nrst_i)
    event_action_control_reg[0] && event_action_control_reg[3] && !cnt_wr |=> $stable(cnt_reg)) // [R23]
    else $error("count moved under a reserved action");

  AST_RISE: assert property (@(posedge clk_i) disable iff (!nrst_i)
    event_action_control_reg[0] && act == tmr_pkg::ACTION_RISING_EDGE && active && !dir_reg
    && ev_s2_reg && !ev_prev_reg && cnt_reg != per_reg && !cnt_wr
    |=> cnt_reg == $past(cnt_reg) + 16'h0001) // [R1]
    else $error("rising event edge not counted");

  AST_DIR_LATCH: assert property (@(posedge clk_i) disable iff (!nrst_i)
    event_action_control_reg[0] && act == tmr_pkg::ACTION_DIRECTION_CONTROL && step
    |=> dir_reg == $past(ev_s2_reg)) // [R4]
    else $error("direction not latched on step");

  AST_IRQ: assert property (@(posedge clk_i) disable iff (!nrst_i)
    flags_reg[0] && inten_reg[0] |=> irq_o) // [R7]
    else $error("enabled wrap flag gave no request");

endmodule

// ### verilog/tmr_pkg.sv
// ****************************************************************
// Constants of the 16-bit event timer.
// ****************************************************************
package tmr_pkg;

  // Byte addresses of the register map.
  localparam logic [7:0] A_CTRL     = 8'h05;
  localparam logic [7:0] A_BVALID   = 8'h06;
  localparam logic [7:0] A_EVENT_ACTION_CONTROL   = 8'h09;
  localparam logic [7:0] A_INTEN    = 8'h0a;
  localparam logic [7:0] A_FLAGS    = 8'h0b;
  localparam logic [7:0] A_DBG      = 8'h0e;
  localparam logic [7:0] A_TEMP     = 8'h0f;
  localparam logic [7:0] A_CNT      = 8'h20;
  localparam logic [7:0] A_PER      = 8'h26;
  localparam logic [7:0] A_CMP      = 8'h28;
  localparam logic [7:0] A_CMP_STEP = 8'h02;
  localparam logic [7:0] A_PERIOD_BUFFER   = 8'h36;
  localparam logic [7:0] A_CMPBUF   = 8'h38;

  // Field positions.
  localparam int EV_EN_BIT  = 0;
  localparam int EV_ACT_LSB = 1;
  localparam int IE_WRAP_BIT = 0;
  localparam int IE_CMP_LSB = 4;
  localparam int CTRL_DIR   = 0;
  localparam int CTRL_LOCK  = 1;
  localparam int CTRL_UPD   = 2;
  localparam int DBG_RUN    = 0;

  // Reset values.
  localparam logic [7:0]  REG8_RST = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [15:0] PER_RST  = 16'hffff;
  localparam logic [15:0] CMP_RST  = 16'h0000;

  // Event action codes.
  typedef enum logic [2:0] {
    ACTION_RISING_EDGE       = 3'h0,
    ACTION_BOTH_EDGES        = 3'h1,
    ACTION_HIGH_LEVEL        = 3'h2,
    ACTION_DIRECTION_CONTROL = 3'h3
  } tmr_act_t;

endpackage

// ### verilog/tmr_cmp_if.sv
`timescale 1ns/1ps
// ****************************************************************
// Link between the timer core and one compare channel.
// ****************************************************************
interface tmr_cmp_if;
  logic [15:0] cnt;
  logic        upd;
  logic [15:0] wdata;
  logic        wr_val;
  logic        wr_buf;
  logic [15:0] val;
  logic [15:0] bufv;
  logic        bv;
  logic        match;
  logic        hit;

  modport core (output cnt, upd, wdata, wr_val, wr_buf,
                input  val, bufv, bv, match, hit);
  modport chan (input  cnt, upd, wdata, wr_val, wr_buf,
                output val, bufv, bv, match, hit);
endinterface

// ### verilog/tmr_cmp_chan.sv
`timescale 1ns/1ps
// ****************************************************************
// One compare channel: value, buffer, valid bit and comparator.
// ****************************************************************
module tmr_cmp_chan (
  input  wire logic clk_i,
  input  wire logic nrst_i,
  tmr_cmp_if.chan   bus
);

  logic [15:0] val_reg;
  logic [15:0] buf_reg;
  logic        bv_reg;
  logic        match_reg;
  logic        hit_reg;

  // The compare value takes direct writes, else a valid buffer on update.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      val_reg <= tmr_pkg::CMP_RST;
    end else if (bus.wr_val) begin
      val_reg <= bus.wdata;
    end else if (bus.upd && bv_reg) begin
      val_reg <= buf_reg; // [R18]
    end
  end

  // The buffer takes writes and marks itself valid; update clears the mark.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      buf_reg <= tmr_pkg::CMP_RST;
      bv_reg  <= 1'b0;
    end else if (bus.wr_buf) begin
      buf_reg <= bus.wdata;
      bv_reg  <= 1'b1; // [R20]
    end else if (bus.upd) begin
      bv_reg  <= 1'b0; // [R20]
    end
  end

  // Continuous comparison; a hit marks the cycle equality begins.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      match_reg <= 1'b0;
      hit_reg   <= 1'b0;
    end else begin
      match_reg <= (bus.cnt == val_reg); // [R17]
      hit_reg   <= (bus.cnt == val_reg) && !match_reg; // [R8]
    end
  end

  assign bus.val   = val_reg;
  assign bus.bufv  = buf_reg;
  assign bus.bv    = bv_reg;
  assign bus.match = match_reg;
  assign bus.hit   = hit_reg;

  AST_BV_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus.wr_buf |=> bv_reg) // [R20]
    else $error("buffer valid not set after buffer write");

  AST_UPD_LOAD: assert property (@(posedge clk_i) disable iff (!nrst_i)
    bus.upd && bv_reg && !bus.wr_val && !bus.wr_buf |=> val_reg == $past(buf_reg) && !bv_reg) // [R18]
    else $error("compare value not loaded from buffer on update");

endmodule

// ### verification/test_tmr_timer16.sv
`timescale 1ns/1ps
// ****************************************************************
// Self-checking bench of the 16-bit event timer.
// ****************************************************************
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end

module test_tmr_timer16;
  logic       clk_i;
  logic       nrst_i;
  logic [7:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic       event_i;
  logic       count_tick_i;
  logic       debug_halt_i;
  logic [7:0] rdata_o;
  logic       irq_o;
  logic [2:0] cmp_match_o;
  int         fail_count;
  int         checks;
  logic [7:0] b;
  logic [15:0] h;

  tmr_timer16 #(.NCH(3)) i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .event_i(event_i),
    .count_tick_i(count_tick_i), .debug_halt_i(debug_halt_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .cmp_match_o(cmp_match_o));

  // ****************************************************************
  // Bus cycles and stimulus helpers.
  // ****************************************************************
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i); addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
    @(posedge clk_i); wr_i <= 1'b0;
  endtask
  // The read data are sampled just after the edge that follows the strobe.
  task automatic rd8(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i); addr_i <= a; rd_i <= 1'b1;
    @(posedge clk_i); rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr8(a, d[7:0]);
    wr8(8'(a + 8'h01), d[15:8]);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(8'(a + 8'h01), d[15:8]);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Ticks are held high for n consecutive cycles.
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i); count_tick_i <= 1'b1;
    end
    @(posedge clk_i); count_tick_i <= 1'b0;
  endtask
  // The wait covers the two-flop event synchroniser.
  task automatic evt(input logic v);
    @(posedge clk_i); event_i <= v;
    idle(4);
  endtask

  // ****************************************************************
  // Scenarios.
  // ****************************************************************
  task automatic t_reset();
    rd16(tmr_pkg::A_PER, h); `CHK(h, 16'hffff)
    for (int n = 0; n < 3; n++) begin
      rd16(8'(tmr_pkg::A_CMP + 8'(2 * n)), h); `CHK(h, 16'h0000)
    end
    rd16(tmr_pkg::A_CNT, h); `CHK(h, 16'h0000)
    rd8(tmr_pkg::A_EVENT_ACTION_CONTROL, b); `CHK(b, 8'h00)
    rd8(tmr_pkg::A_INTEN, b); `CHK(b, 8'h00)
    rd8(8'h7f, b); `CHK(b, 8'h00)
    $display("test reset done");
  endtask
  task automatic t_access();
    wr16(tmr_pkg::A_CNT, 16'h1234);
    rd16(tmr_pkg::A_CNT, h); `CHK(h, 16'h1234)
    rd8(tmr_pkg::A_CNT, b);
    rd8(tmr_pkg::A_TEMP, b); `CHK(b, 8'h12)
    wr8(tmr_pkg::A_TEMP, 8'h5a);
    rd8(tmr_pkg::A_TEMP, b); `CHK(b, 8'h5a)
    $display("test access done");
  endtask
  // Two event pulses give two or four steps; a reserved code gives none.
  task automatic t_edges();
    for (int a = 0; a < 3; a++) begin
      wr16(tmr_pkg::A_CNT, 16'h0000);
      wr8(tmr_pkg::A_EVENT_ACTION_CONTROL, (a == 2) ? 8'h0b : 8'(2 * a + 1));
      repeat (2) begin
        evt(1'b1); evt(1'b0);
      end
      if (a == 2) ticks(3);
      rd16(tmr_pkg::A_CNT, h);
      if (a < 2) `CHK(h, (a == 1) ? 16'h0004 : 16'h0002)
      else `CHK(h, 16'h0000)
    end
    $display("test edges done");
  endtask
  task automatic t_level_dir();
    wr16(tmr_pkg::A_CNT, 16'h0000);
    wr8(tmr_pkg::A_EVENT_ACTION_CONTROL, 8'h05);
    ticks(2); evt(1'b1); ticks(5); evt(1'b0); ticks(3);
    rd16(tmr_pkg::A_CNT, h); `CHK(h, 16'h0005)
    wr16(tmr_pkg::A_CNT, 16'h000a);
    wr8(tmr_pkg::A_EVENT_ACTION_CONTROL, 8'h07);
    ticks(3); evt(1'b1); ticks(5); evt(1'b0); ticks(1);
    rd16(tmr_pkg::A_CNT, h); `CHK(h, 16'h0009)
    wr8(tmr_pkg::A_EVENT_ACTION_CONTROL, 8'h00);
    $display("test level and direction done");
  endtask
  task automatic t_debug();
    wr16(tmr_pkg::A_CNT, 16'h0000);
    @(posedge clk_i); debug_halt_i <= 1'b1;
    ticks(4);
    rd16(tmr_pkg::A_CNT, h); `CHK(h, 16'h0000)
    wr8(tmr_pkg::A_DBG, 8'h01);
    ticks(4);
    rd16(tmr_pkg::A_CNT, h); `CHK(h, 16'h0004)
    @(posedge clk_i); debug_halt_i <= 1'b0;
    wr8(tmr_pkg::A_DBG, 8'h00);
    $display("test debug done");
  endtask
  // Each channel in turn matches at five, raises its flag and request.
  task automatic t_compare();
    for (int n = 0; n < 3; n++) begin
      wr16(8'(tmr_pkg::A_CMP + 8'(2 * n)), 16'h0005);
      wr16(tmr_pkg::A_CNT, 16'h0000);
      wr8(tmr_pkg::A_FLAGS, 8'h71);
      wr8(tmr_pkg::A_INTEN, 8'(8'h10 << n));
      ticks(5); idle(3);
      `CHK(cmp_match_o[n], 1'b1)
      rd8(tmr_pkg::A_FLAGS, b); `CHK(b[4+n], 1'b1)
      `CHK(irq_o, 1'b1)
      ticks(1); idle(3);
      rd8(tmr_pkg::A_FLAGS, b); `CHK(b[4+n], 1'b1)
      wr8(tmr_pkg::A_FLAGS, 8'(8'h10 << n)); idle(2);
      rd8(tmr_pkg::A_FLAGS, b); `CHK(b[4+n], 1'b0)
      `CHK(irq_o, 1'b0)
    end
    wr8(tmr_pkg::A_INTEN, 8'h00);
    $display("test compare done");
  endtask
  task automatic t_wrap();
    wr16(tmr_pkg::A_PER, 16'h0003);
    wr16(tmr_pkg::A_CNT, 16'h0000);
    wr8(tmr_pkg::A_FLAGS, 8'h71);
    wr8(tmr_pkg::A_INTEN, 8'h01);
    ticks(4); idle(2);
    rd8(tmr_pkg::A_FLAGS, b); `CHK(b[0], 1'b1)
    `CHK(irq_o, 1'b1)
    rd16(tmr_pkg::A_CNT, h); `CHK(h, 16'h0000)
    rd8(tmr_pkg::A_FLAGS, b); `CHK(b[0], 1'b1)
    wr8(tmr_pkg::A_FLAGS, 8'h01); idle(2);
    rd8(tmr_pkg::A_FLAGS, b); `CHK(b[0], 1'b0)
    `CHK(irq_o, 1'b0)
    wr8(tmr_pkg::A_INTEN, 8'h00);
    $display("test wrap done");
  endtask
  // A commanded update loads the buffers even while updates are locked.
  task automatic t_update();
    wr16(tmr_pkg::A_CMPBUF, 16'h0042);
    wr16(tmr_pkg::A_PERIOD_BUFFER, 16'h0100);
    rd8(tmr_pkg::A_BVALID, b); `CHK(b[1:0], 2'b11)
    wr8(tmr_pkg::A_CTRL, 8'h02);
    wr8(tmr_pkg::A_CTRL, 8'h06);
    rd16(tmr_pkg::A_CMP, h); `CHK(h, 16'h0042)
    rd8(tmr_pkg::A_BVALID, b); `CHK(b[3:0], 4'h0)
    wr16(tmr_pkg::A_CMPBUF, 16'h0077);
    wr16(tmr_pkg::A_CNT, 16'h0100);
    ticks(1); idle(1);
    rd16(tmr_pkg::A_CMP, h); `CHK(h, 16'h0042)
    wr8(tmr_pkg::A_CTRL, 8'h00);
    wr16(tmr_pkg::A_CNT, 16'h0100);
    ticks(1); idle(1);
    rd16(tmr_pkg::A_CMP, h); `CHK(h, 16'h0077)
    $display("test update done");
  endtask

  // ****************************************************************
  // Clock, sequence, watchdog and verdict.
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d failures %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // The clock runs at 40 MHz.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Main sequence with reset held for four cycles.
  initial begin
    {nrst_i, wr_i, rd_i, event_i, count_tick_i, debug_halt_i} = 6'h00;
    addr_i = 8'h00; wdata_i = 8'h00; fail_count = 0; checks = 0;
    idle(3);
    @(posedge clk_i); nrst_i <= 1'b1;
    t_reset(); t_access(); t_edges(); t_level_dir();
    t_debug(); t_compare(); t_wrap(); t_update();
    summarize();
  end
  // The tests need under five hundred cycles; this cuts a hang short.
  initial begin
    idle(20000);
    fail_count++;
    summarize();
  end
endmodule
